// ### design/csb_constant_sample_and_bias_regs.sv
// Overview of operation
// - While the hold bit is set, new constant sample words are not passed on and channels keep their present sample.
// - While the hold bit is clear, the programmed constant sample word is driven to every channel using the constant source.
// - A 16-bit read-write constant sample word, reset to zero, supplies the fixed sample for constant-source channels.
// - A released constant sample update reaches both channels in the same clock cycle.
// - The channel B current register holds a 6-bit fine trim in bits 5-0 resetting to 1Fh and a read-write reserved bit 6 resetting to 0.
// - Bit 7 of the channel B current register is a read-write current enable resetting to 1, so the register resets to 9Fh.
// - The 16-bit shunt regulator enable register resets to 0, with two-bit fields per channel supply, single bits 15-13 and reserved bit 12.
//
// Strobed register access is this design's own decision.

`timescale 1ns/100ps
`default_nettype none
`include "csb_cfg.svh"

module csb_constant_sample_and_bias_regs
   import csb_pkg::*;
#(
   parameter int  AW = `CSB_ADDR_W,
   parameter int  DW = `CSB_DATA_W
) (
   input  wire logic           clk,
   input  wire logic           sys_rst,
   input  wire logic [AW-1:0]  reg_addr,
   input  wire logic [DW-1:0]  reg_wdata,
   input  wire logic           reg_wr,
   input  wire logic           reg_rd,
   output logic      [DW-1:0]  reg_rdata,
   input  wire logic           datapath_on,
   input  wire logic           chan_a_source_select,
   input  wire logic           chan_b_source_select,
   output logic      [DW-1:0]  chan_a_const_sample,
   output logic      [DW-1:0]  chan_b_const_sample,
   output logic                chan_a_const_active,
   output logic                chan_b_const_active,
   output logic                chan_b_current_on,
   output logic      [5:0]     chan_b_fine_trim,
   output logic                clock_dist_reg_on,
   output logic                clock_gen_reg_on,
   output logic                sync_receiver_reg_on,
   output logic      [1:0]     chan_b_mux_supply_reg_on,
   output logic      [1:0]     chan_b_switch_drv_reg_on,
   output logic      [1:0]     chan_b_clock_drv_reg_on,
   output logic      [1:0]     chan_a_mux_supply_reg_on,
   output logic      [1:0]     chan_a_switch_drv_reg_on,
   output logic      [1:0]     chan_a_clock_drv_reg_on
);

   csb_reg_sel_t  wr_sel;
   csb_reg_sel_t  rd_sel;

   logic          wr_channel_b_current_control;
   logic          wr_hold;
   logic          wr_value;
   logic          wr_shunt;
   logic          wr_status;

   logic [7:0]    channel_b_current_control_q;
   logic [7:0]    hold_q;
   logic [DW-1:0] value_q;
   logic [DW-1:0] shunt_q;

   logic          const_sample_hold;
   logic          update_pending;
   logic          viol_event;
   logic          viol_reg;
   logic          viol_next;

   logic [DW-1:0] status_word;
   logic [DW-1:0] rdata_reg;
   logic [DW-1:0] rdata_next;

   // Address decode, shared by write and read paths
   assign wr_sel    = csb_decode(reg_addr);
   assign rd_sel    = csb_decode(reg_addr);

   assign wr_channel_b_current_control  = reg_wr && (wr_sel == CSB_SEL_CHANNEL_B_CURRENT_CONTROL);
   assign wr_hold   = reg_wr && (wr_sel == CSB_SEL_HOLD);
   assign wr_value  = reg_wr && (wr_sel == CSB_SEL_VALUE);
   assign wr_shunt  = reg_wr && (wr_sel == CSB_SEL_SHUNT);
   assign wr_status = reg_wr && (wr_sel == CSB_SEL_STATUS);

   // Channel B current control: enable, reserved bit, fine trim
   csb_rw_field #(
      .W   (8),
      .RST (`CSB_RST_CHANNEL_B_CURRENT_CONTROL)
   ) u_channel_b_current_control (
      .clk     (clk),
      .sys_rst (sys_rst),
      .wr_en   (wr_channel_b_current_control),
      .wdata   (reg_wdata[`CSB_BYTE_HI:0]),
      .q       (channel_b_current_control_q)
   );

   assign chan_b_current_on = channel_b_current_control_q[`CSB_CUR_ON_BIT];
   assign chan_b_fine_trim  = channel_b_current_control_q[`CSB_TRIM_HI:`CSB_TRIM_LO];

   // Hold bit plus seven reserved bits that still store
   csb_rw_field #(
      .W   (8),
      .RST (`CSB_RST_HOLD)
   ) u_hold (
      .clk     (clk),
      .sys_rst (sys_rst),
      .wr_en   (wr_hold),
      .wdata   (reg_wdata[`CSB_BYTE_HI:0]),
      .q       (hold_q)
   );

   assign const_sample_hold = hold_q[`CSB_HOLD_BIT];

   // Constant sample word
   csb_rw_field #(
      .W   (DW),
      .RST (DW'(`CSB_RST_VALUE))
   ) u_value (
      .clk     (clk),
      .sys_rst (sys_rst),
      .wr_en   (wr_value),
      .wdata   (reg_wdata),
      .q       (value_q)
   );

   // Shunt regulator enables; zero after reset, software is expected to set them
   csb_rw_field #(
      .W   (DW),
      .RST (DW'(`CSB_RST_SHUNT))
   ) u_shunt (
      .clk     (clk),
      .sys_rst (sys_rst),
      .wr_en   (wr_shunt),
      .wdata   (reg_wdata),
      .q       (shunt_q)
   );

   assign clock_dist_reg_on        = shunt_q[`CSB_SH_CLKDIST_BIT];
   assign clock_gen_reg_on         = shunt_q[`CSB_SH_CLKGEN_BIT];
   assign sync_receiver_reg_on     = shunt_q[`CSB_SH_SYNCRX_BIT];
   assign chan_b_mux_supply_reg_on = shunt_q[`CSB_SH_MUX_B_HI:`CSB_SH_MUX_B_LO];
   assign chan_b_switch_drv_reg_on = shunt_q[`CSB_SH_SWDRV_B_HI:`CSB_SH_SWDRV_B_LO];
   assign chan_b_clock_drv_reg_on  = shunt_q[`CSB_SH_CLKDRV_B_HI:`CSB_SH_CLKDRV_B_LO];
   assign chan_a_mux_supply_reg_on = shunt_q[`CSB_SH_MUX_A_HI:`CSB_SH_MUX_A_LO];
   assign chan_a_switch_drv_reg_on = shunt_q[`CSB_SH_SWDRV_A_HI:`CSB_SH_SWDRV_A_LO];
   assign chan_a_clock_drv_reg_on  = shunt_q[`CSB_SH_CLKDRV_A_HI:`CSB_SH_CLKDRV_A_LO];

   // Release path toward the sample datapath
   csb_const_path #(
      .W (DW)
   ) u_const_path (
      .clk                 (clk),
      .sys_rst             (sys_rst),
      .const_sample_hold   (const_sample_hold),
      .const_sample_word   (value_q),
      .chan_a_uses_const   (chan_a_source_select),
      .chan_b_uses_const   (chan_b_source_select),
      .chan_a_const_sample (chan_a_const_sample),
      .chan_b_const_sample (chan_b_const_sample),
      .chan_a_const_active (chan_a_const_active),
      .chan_b_const_active (chan_b_const_active),
      .update_pending      (update_pending)
   );

   // Word written while live and unheld may glitch the output; remember it
   assign viol_event = wr_value && datapath_on && !const_sample_hold;

   // Set wins over a write-one clear in the same cycle
   always_comb begin
      viol_next = viol_reg;
      if (wr_status && reg_wdata[`CSB_ST_VIOL_BIT]) begin
         viol_next = 1'b0;
      end
      if (viol_event) begin
         viol_next = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         viol_reg <= 1'b0;
      end else begin
         viol_reg <= viol_next;
      end
   end

   always_comb begin
      status_word                      = '0;
      status_word[`CSB_ST_PENDING_BIT] = update_pending;
      status_word[`CSB_ST_VIOL_BIT]    = viol_reg;
      status_word[`CSB_ST_HOLD_BIT]    = const_sample_hold;
   end

   // Read mux; narrow registers zero-extended, unmapped reads give zero
   always_comb begin
      rdata_next = '0;
      if (reg_rd) begin
         case (rd_sel)
            CSB_SEL_CHANNEL_B_CURRENT_CONTROL  : rdata_next = {{(DW-8){1'b0}}, channel_b_current_control_q};
            CSB_SEL_HOLD   : rdata_next = {{(DW-8){1'b0}}, hold_q};
            CSB_SEL_VALUE  : rdata_next = value_q;
            CSB_SEL_SHUNT  : rdata_next = shunt_q;
            CSB_SEL_STATUS : rdata_next = status_word;
            default        : rdata_next = '0;
         endcase
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;

endmodule

`default_nettype wire

// ### design/csb_cfg.svh
`ifndef CSB_CFG_SVH
`define CSB_CFG_SVH

// Register map
`define CSB_ADDR_W            12
`define CSB_DATA_W            16
`define CSB_ADDR_CHANNEL_B_CURRENT_CONTROL        12'h172
`define CSB_ADDR_HOLD         12'h180
`define CSB_ADDR_VALUE        12'h181
`define CSB_ADDR_SHUNT        12'h1a0
`define CSB_ADDR_STATUS       12'h182

// Reset values
`define CSB_RST_CHANNEL_B_CURRENT_CONTROL         8'h9f
`define CSB_RST_HOLD          8'h00
`define CSB_RST_VALUE         16'h0000
`define CSB_RST_SHUNT         16'h0000
`define CSB_RST_SAMPLE        16'h0000

// Current control fields
`define CSB_CUR_ON_BIT        7
`define CSB_TRIM_HI           5
`define CSB_TRIM_LO           0
`define CSB_BYTE_HI           7

// Hold register field
`define CSB_HOLD_BIT          0

// Shunt regulator fields
`define CSB_SH_CLKDIST_BIT    15
`define CSB_SH_CLKGEN_BIT     14
`define CSB_SH_SYNCRX_BIT     13
`define CSB_SH_MUX_B_HI       11
`define CSB_SH_MUX_B_LO       10
`define CSB_SH_SWDRV_B_HI     9
`define CSB_SH_SWDRV_B_LO     8
`define CSB_SH_CLKDRV_B_HI    7
`define CSB_SH_CLKDRV_B_LO    6
`define CSB_SH_MUX_A_HI       5
`define CSB_SH_MUX_A_LO       4
`define CSB_SH_SWDRV_A_HI     3
`define CSB_SH_SWDRV_A_LO     2
`define CSB_SH_CLKDRV_A_HI    1
`define CSB_SH_CLKDRV_A_LO    0

// Status register fields
`define CSB_ST_PENDING_BIT    0
`define CSB_ST_VIOL_BIT       1
`define CSB_ST_HOLD_BIT       2

`endif

// ### design/csb_pkg.sv
`include "csb_cfg.svh"

package csb_pkg;

   typedef enum logic [2:0] {
      CSB_SEL_NONE,
      CSB_SEL_CHANNEL_B_CURRENT_CONTROL,
      CSB_SEL_HOLD,
      CSB_SEL_VALUE,
      CSB_SEL_SHUNT,
      CSB_SEL_STATUS
   } csb_reg_sel_t;

   function automatic csb_reg_sel_t csb_decode(input logic [`CSB_ADDR_W-1:0] addr);
      case (addr)
         `CSB_ADDR_CHANNEL_B_CURRENT_CONTROL  : csb_decode = CSB_SEL_CHANNEL_B_CURRENT_CONTROL;
         `CSB_ADDR_HOLD   : csb_decode = CSB_SEL_HOLD;
         `CSB_ADDR_VALUE  : csb_decode = CSB_SEL_VALUE;
         `CSB_ADDR_SHUNT  : csb_decode = CSB_SEL_SHUNT;
         `CSB_ADDR_STATUS : csb_decode = CSB_SEL_STATUS;
         default          : csb_decode = CSB_SEL_NONE;
      endcase
   endfunction

endpackage

// ### design/csb_rw_field.sv
`timescale 1ns/100ps
`default_nettype none

module csb_rw_field
   import csb_pkg::*;
#(
   parameter int             W   = 8,
   parameter logic [W-1:0]   RST = '0
) (
   input  wire logic          clk,
   input  wire logic          sys_rst,
   input  wire logic          wr_en,
   input  wire logic [W-1:0]  wdata,
   output logic      [W-1:0]  q
);

   logic [W-1:0] field_reg;

   // Every bit, reserved ones too, keeps what was last written
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         field_reg <= RST;
      end else if (wr_en) begin
         field_reg <= wdata;
      end
   end

   assign q = field_reg;

endmodule

`default_nettype wire

// ### design/csb_const_path.sv
`timescale 1ns/100ps
`default_nettype none
`include "csb_cfg.svh"

module csb_const_path
   import csb_pkg::*;
#(
   parameter int  W = `CSB_DATA_W
) (
   input  wire logic          clk,
   input  wire logic          sys_rst,
   input  wire logic          const_sample_hold,
   input  wire logic [W-1:0]  const_sample_word,
   input  wire logic          chan_a_uses_const,
   input  wire logic          chan_b_uses_const,
   output logic      [W-1:0]  chan_a_const_sample,
   output logic      [W-1:0]  chan_b_const_sample,
   output logic               chan_a_const_active,
   output logic               chan_b_const_active,
   output logic               update_pending
);

   logic [W-1:0] chan_a_sample_reg;
   logic [W-1:0] chan_b_sample_reg;
   logic         chan_a_active_reg;
   logic         chan_b_active_reg;
   logic         load_now;

   // One shared load term so both channels can never disagree
   assign load_now = !const_sample_hold;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         chan_a_sample_reg <= W'(`CSB_RST_SAMPLE);
         chan_b_sample_reg <= W'(`CSB_RST_SAMPLE);
      end else if (load_now) begin
         chan_a_sample_reg <= const_sample_word;
         chan_b_sample_reg <= const_sample_word;
      end
   end

   // Selection is outside this block; only flag which channels take the word
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         chan_a_active_reg <= 1'b0;
         chan_b_active_reg <= 1'b0;
      end else begin
         chan_a_active_reg <= chan_a_uses_const;
         chan_b_active_reg <= chan_b_uses_const;
      end
   end

   assign chan_a_const_sample = chan_a_sample_reg;
   assign chan_b_const_sample = chan_b_sample_reg;
   assign chan_a_const_active = chan_a_active_reg;
   assign chan_b_const_active = chan_b_active_reg;
   assign update_pending      = (chan_a_sample_reg != const_sample_word);

endmodule

`default_nettype wire

// ### test/csb_regs_chk.sv
`timescale 1ns/100ps
`default_nettype none

module csb_regs_chk (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic [11:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic        chan_a_source_select,
   input wire logic [15:0] chan_a_const_sample,
   input wire logic [15:0] chan_b_const_sample,
   input wire logic        chan_a_const_active,
   input wire logic        chan_b_current_on,
   input wire logic [5:0]  chan_b_fine_trim,
   input wire logic        clock_dist_reg_on,
   input wire logic        clock_gen_reg_on,
   input wire logic        sync_receiver_reg_on,
   input wire logic [1:0]  chan_b_mux_supply_reg_on,
   input wire logic [1:0]  chan_b_switch_drv_reg_on,
   input wire logic [1:0]  chan_b_clock_drv_reg_on,
   input wire logic [1:0]  chan_a_mux_supply_reg_on,
   input wire logic [1:0]  chan_a_switch_drv_reg_on,
   input wire logic [1:0]  chan_a_clock_drv_reg_on
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   // Shadow of hold bit and word, same timing as the real registers
   logic        hold_m;
   logic [15:0] word_m;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hold_m <= 1'b0;
         word_m <= 16'h0000;
      end else if (reg_wr) begin
         if (reg_addr == 12'h180) hold_m <= reg_wdata[0];
         if (reg_addr == 12'h181) word_m <= reg_wdata;
      end
   end

   hold_freeze_a: assert property (hold_m |=> $stable(chan_a_const_sample))
      else $error("sample moved while hold set");
   word_forward_a: assert property (!hold_m |=> chan_a_const_sample == $past(word_m))
      else $error("sample not loaded from word");
   both_chan_a: assert property (chan_a_const_sample == chan_b_const_sample)
      else $error("channels differ");
   word_read_a: assert property (reg_rd && reg_addr == 12'h181 |=> reg_rdata == word_m)
      else $error("word readback wrong");
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data outside read slot");
   cur_reset_a: assert property ($fell(sys_rst) |-> chan_b_current_on && chan_b_fine_trim == 6'h1f)
      else $error("current control reset value wrong");
   cur_write_a: assert property (reg_wr && reg_addr == 12'h172 |=>
      {chan_b_current_on, chan_b_fine_trim} == {$past(reg_wdata[7]), $past(reg_wdata[5:0])})
      else $error("current fields not written");
   shunt_write_a: assert property (reg_wr && reg_addr == 12'h1a0 |=>
      {clock_dist_reg_on, clock_gen_reg_on, sync_receiver_reg_on, chan_b_mux_supply_reg_on,
       chan_b_switch_drv_reg_on, chan_b_clock_drv_reg_on, chan_a_mux_supply_reg_on,
       chan_a_switch_drv_reg_on, chan_a_clock_drv_reg_on} == {$past(reg_wdata[15:13]), $past(reg_wdata[11:0])})
      else $error("shunt fields not written");
   active_copy_a: assert property (!$past(sys_rst) |-> chan_a_const_active == $past(chan_a_source_select))
      else $error("active flag not one cycle behind select");
endmodule

`default_nettype wire

// ### test/csb_constant_sample_and_bias_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none

module csb_constant_sample_and_bias_regs_bench;
   logic        clk, sys_rst, reg_wr, reg_rd, datapath_on;
   logic        chan_a_source_select, chan_b_source_select;
   logic [11:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, chan_a_const_sample, chan_b_const_sample;
   logic        chan_a_const_active, chan_b_const_active, chan_b_current_on;
   logic [5:0]  chan_b_fine_trim;
   logic        clock_dist_reg_on, clock_gen_reg_on, sync_receiver_reg_on;
   logic [1:0]  chan_b_mux_supply_reg_on, chan_b_switch_drv_reg_on, chan_b_clock_drv_reg_on;
   logic [1:0]  chan_a_mux_supply_reg_on, chan_a_switch_drv_reg_on, chan_a_clock_drv_reg_on;
   int          err_count, samples_checked, cycles;
   logic [11:0] wa [5] = '{12'h172, 12'h180, 12'h1a0, 12'h1a0, 12'h1a1};
   logic [15:0] wv [5] = '{16'hff40, 16'h00fe, 16'h0fff, 16'hf555, 16'hffff};
   logic [15:0] we [5] = '{16'h0040, 16'h00fe, 16'h0fff, 16'hf555, 16'h0000};

   // Bit 6 and bit 12 have no output pin, so the views hold them at 0
   wire logic [15:0] cur_view   = {8'h00, chan_b_current_on, 1'b0, chan_b_fine_trim};
   wire logic [15:0] shunt_view = {clock_dist_reg_on, clock_gen_reg_on, sync_receiver_reg_on, 1'b0,
      chan_b_mux_supply_reg_on, chan_b_switch_drv_reg_on, chan_b_clock_drv_reg_on,
      chan_a_mux_supply_reg_on, chan_a_switch_drv_reg_on, chan_a_clock_drv_reg_on};

   csb_constant_sample_and_bias_regs csb_constant_sample_and_bias_regs_inst (
      .clk                      (clk),
      .sys_rst                  (sys_rst),
      .reg_addr                 (reg_addr),
      .reg_wdata                (reg_wdata),
      .reg_wr                   (reg_wr),
      .reg_rd                   (reg_rd),
      .reg_rdata                (reg_rdata),
      .datapath_on              (datapath_on),
      .chan_a_source_select     (chan_a_source_select),
      .chan_b_source_select     (chan_b_source_select),
      .chan_a_const_sample      (chan_a_const_sample),
      .chan_b_const_sample      (chan_b_const_sample),
      .chan_a_const_active      (chan_a_const_active),
      .chan_b_const_active      (chan_b_const_active),
      .chan_b_current_on        (chan_b_current_on),
      .chan_b_fine_trim         (chan_b_fine_trim),
      .clock_dist_reg_on        (clock_dist_reg_on),
      .clock_gen_reg_on         (clock_gen_reg_on),
      .sync_receiver_reg_on     (sync_receiver_reg_on),
      .chan_b_mux_supply_reg_on (chan_b_mux_supply_reg_on),
      .chan_b_switch_drv_reg_on (chan_b_switch_drv_reg_on),
      .chan_b_clock_drv_reg_on  (chan_b_clock_drv_reg_on),
      .chan_a_mux_supply_reg_on (chan_a_mux_supply_reg_on),
      .chan_a_switch_drv_reg_on (chan_a_switch_drv_reg_on),
      .chan_a_clock_drv_reg_on  (chan_a_clock_drv_reg_on)
   );

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One idle cycle after each strobe keeps every signal to one assignment per step
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [15:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
      @(posedge clk);
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         err_count++;
         summarize();
      end
   end

   initial begin
      sys_rst = 1'b1;
      reg_addr = 12'h000;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      datapath_on = 1'b0;
      chan_a_source_select = 1'b0;
      chan_b_source_select = 1'b0;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk);
      chk(cur_view, 16'h009f);
      chk(shunt_view, 16'h0000);
      chk({14'h0, chan_a_const_active, chan_b_const_active}, 16'h0000);
      rd(12'h172, 16'h009f);
      rd(12'h180, 16'h0000);
      rd(12'h181, 16'h0000);
      rd(12'h1a0, 16'h0000);
      $display("reset values test done");
      for (int i = 0; i < 5; i++) begin
         wr(wa[i], wv[i]);
         rd(wa[i], we[i]);
      end
      chk(cur_view, 16'h0000);
      chk(shunt_view, 16'he555);
      $display("readback test done");
      chan_a_source_select <= 1'b1;
      chan_b_source_select <= 1'b1;
      wr(12'h181, 16'h1234);
      @(posedge clk);
      chk(chan_a_const_sample, 16'h1234);
      chk(chan_b_const_sample, 16'h1234);
      chk({14'h0, chan_a_const_active, chan_b_const_active}, 16'h0003);
      datapath_on <= 1'b1;
      wr(12'h180, 16'h0001);
      wr(12'h181, 16'hbeef);
      repeat (4) @(posedge clk);
      chk(chan_a_const_sample, 16'h1234);
      chk(chan_b_const_sample, 16'h1234);
      rd(12'h181, 16'hbeef);
      rd(12'h182, 16'h0005);
      wr(12'h180, 16'h0000);
      @(posedge clk);
      chk(chan_a_const_sample, 16'hbeef);
      chk(chan_b_const_sample, 16'hbeef);
      $display("constant sample test done");
      // Word changed live with hold clear: sticky flag set, then cleared by writing one
      wr(12'h181, 16'h5a5a);
      rd(12'h182, 16'h0002);
      wr(12'h182, 16'h0002);
      rd(12'h182, 16'h0000);
      $display("status test done");
      summarize();
   end
endmodule

bind csb_constant_sample_and_bias_regs csb_regs_chk chk_inst (
   .clk                      (clk),
   .sys_rst                  (sys_rst),
   .reg_addr                 (reg_addr),
   .reg_wdata                (reg_wdata),
   .reg_wr                   (reg_wr),
   .reg_rd                   (reg_rd),
   .reg_rdata                (reg_rdata),
   .chan_a_source_select     (chan_a_source_select),
   .chan_a_const_sample      (chan_a_const_sample),
   .chan_b_const_sample      (chan_b_const_sample),
   .chan_a_const_active      (chan_a_const_active),
   .chan_b_current_on        (chan_b_current_on),
   .chan_b_fine_trim         (chan_b_fine_trim),
   .clock_dist_reg_on        (clock_dist_reg_on),
   .clock_gen_reg_on         (clock_gen_reg_on),
   .sync_receiver_reg_on     (sync_receiver_reg_on),
   .chan_b_mux_supply_reg_on (chan_b_mux_supply_reg_on),
   .chan_b_switch_drv_reg_on (chan_b_switch_drv_reg_on),
   .chan_b_clock_drv_reg_on  (chan_b_clock_drv_reg_on),
   .chan_a_mux_supply_reg_on (chan_a_mux_supply_reg_on),
   .chan_a_switch_drv_reg_on (chan_a_switch_drv_reg_on),
   .chan_a_clock_drv_reg_on  (chan_a_clock_drv_reg_on)
);

`default_nettype wire
